// File: i2sq_pkg.sv
/*
 package for the i2c master stop sequencer: state codes and timing constants.
 assumes a single 40 mhz system clock domain and a 7-bit baud reload value.

 // Behaviour
 // - scl held low after ninth falling edge
 // - first stop step drives sda low
 // - sda seen low: reload baud, count to zero
 // - timeout releases scl, one period later sda
 // - sda high with scl high sets stop seen
 // - one period later clear enable, set irq flag
 // - buffer write during stop discarded, collision set
*/
package i2sq_pkg;
   localparam int unsigned BAUD_W     = 7;           // baud reload width
   localparam int unsigned DATA_W     = 8;           // transfer buffer width
   localparam logic [BAUD_W-1:0] BAUD_ZERO = 7'h00;  // terminal count
   localparam logic [DATA_W-1:0] BUF_RESET = 8'h00;  // buffer reset value

   // stop sequence states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE     = 6'h01,  // no stop pending, scl low only if parked by a transfer end
      ST_SDA_LOW  = 6'h02,  // sda driven low, waiting to see it low
      ST_SCL_WAIT = 6'h04,  // first baud period before scl release
      ST_SCL_HIGH = 6'h08,  // scl released, waiting for it to read high
      ST_SDA_WAIT = 6'h10,  // second baud period before sda release
      ST_DONE     = 6'h20   // stop seen, final baud period
   } i2sq_state_t;
endpackage : i2sq_pkg

// File: i2sq_baud.sv
/*
 baud rate down counter: reloads on demand and flags its zero count.
 assumes reload and run come from the sequencer in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module i2sq_baud
   import i2sq_pkg::*;
(
   input  wire logic              sys_clk,   // system clock
   input  wire logic              rst,       // async reset, high
   input  wire logic              reload,    // load period value
   input  wire logic              run,       // count while high
   input  wire logic [BAUD_W-1:0] period,    // reload value
   output logic                   timeout    // zero-count flag, held high while run stays high
);
   logic [BAUD_W-1:0] count;  // current count

   // count down; a zero reload times out on the next cycle at once
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count   <= BAUD_ZERO;
         timeout <= 1'b0;
      end else if (reload) begin
         count   <= period;
         timeout <= 1'b0;
      end else if (run && count != BAUD_ZERO) begin
         count   <= count - 1'b1;
         timeout <= (count == 7'h01);
      end else begin
         timeout <= run && (count == BAUD_ZERO);
      end
   end
endmodule : i2sq_baud
`default_nettype wire

// File: i2sq_stop.sv
/*
 i2c master stop sequencer: after a transfer ends it parks scl low, then
 on request drives the stop condition, reports it and blocks buffer writes.
 assumes open-drain bus pins with the pad resolving levels; inputs are
 synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module i2sq_stop
   import i2sq_pkg::*;
(
   input  wire logic              sys_clk,              // 40 mhz clock
   input  wire logic              rst,                  // async reset, high
   input  wire logic              xfer_end,             // ninth scl fall seen
   input  wire logic              stop_sequence_set,    // software sets enable
   input  wire logic [BAUD_W-1:0] baud_reload_period,   // half bus period
   input  wire logic              buf_wr,               // buffer write strobe
   input  wire logic [DATA_W-1:0] buf_wdata,            // buffer write data
   input  wire logic              write_collision_flag_clr,             // software clears write_collision_flag
   input  wire logic              irq_clr,              // software clears irq
   input  wire logic              stop_clr,             // clears stop seen
   input  wire logic              scl_in,               // scl line level
   input  wire logic              sda_in,               // sda line level
   output logic                   scl_oe,               // pull scl low
   output logic                   scl_out,              // always 0 when driven
   output logic                   sda_oe,               // pull sda low
   output logic                   sda_out,              // always 0 when driven
   output logic                   stop_sequence_enable, // stop in progress
   output logic                   stop_detected,        // stop seen status
   output logic                   serial_port_irq_flag, // completion flag
   output logic                   write_collision_flag, // write refused
   output logic [DATA_W-1:0]      transfer_buffer       // buffer contents
);
   i2sq_state_t state;        // sequencer state
   i2sq_state_t next_state;   // state for next cycle
   logic        baud_reload;  // reload the baud counter
   logic        baud_run;     // let it count
   logic        baud_tmo;     // baud period elapsed
   logic        stop_done;    // final period finished

   i2sq_baud u_baud (
      .sys_clk (sys_clk),
      .rst     (rst),
      .reload  (baud_reload),
      .run     (baud_run),
      .period  (baud_reload_period),
      .timeout (baud_tmo)
   );

   // next state; idle waits on the request, every other wait on a line level or the baud timeout.
   // the counter is reloaded on each move into a timed wait and held reloaded in
   // ST_DONE while the lines are not both high, so a period
   // always starts at the edge at which its wait condition was met
   always_comb begin
      next_state  = state;
      baud_reload = 1'b0;
      baud_run    = 1'b0;
      unique case (state)
         // parked: scl stays low after the transfer until software asks
         ST_IDLE: begin
            if (stop_sequence_set) begin
               next_state = ST_SDA_LOW;
            end
         end
         // sda pulled low; wait to read it low before timing anything
         ST_SDA_LOW: begin
            if (!sda_in) begin
               baud_reload = 1'b1;
               next_state  = ST_SCL_WAIT;
            end
         end
         // first period with both lines low
         ST_SCL_WAIT: begin
            baud_run = 1'b1;
            if (baud_tmo) begin
               next_state = ST_SCL_HIGH;
            end
         end
         // scl let go; a slave stretching it delays the count start
         ST_SCL_HIGH: begin
            if (scl_in) begin
               baud_reload = 1'b1;
               next_state  = ST_SDA_WAIT;
            end
         end
         // second period; sda is let go at its end and the final
         // period is loaded at that same edge
         ST_SDA_WAIT: begin
            baud_run = 1'b1;
            if (baud_tmo) begin
               baud_reload = 1'b1;
               next_state  = ST_DONE;
            end
         end
         // final period runs only while the stop shows on the bus; a
         // line held low elsewhere keeps the count parked, so the block
         // waits rather than report a stop that never reached the bus
         ST_DONE: begin
            if (sda_in && scl_in) begin
               baud_run = 1'b1;
            end else begin
               baud_reload = 1'b1;                                // hold
            end
            if (baud_tmo) begin
               next_state = ST_IDLE;
            end
         end
         // an illegal code falls back to idle
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // completion: the final period has run out with the stop seen
   assign stop_done = (state == ST_DONE) && baud_tmo;

   // state register; every move comes from the next-state logic so the
   // counter control and the state can never disagree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // scl drive: parked low after a transfer, released on first timeout.
   // a new transfer end wins over the release, so a late strobe can
   // never leave the clock floating in the middle of a byte
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_oe <= 1'b0;
      end else if (xfer_end) begin
         scl_oe <= 1'b1;
      end else if (state == ST_SCL_WAIT && baud_tmo) begin
         scl_oe <= 1'b0;
      end
   end

   // sda drive: low for the stop start, released after second period;
   // it is only ever taken low from idle, never in mid-sequence
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sda_oe <= 1'b0;
      end else if (state == ST_IDLE && stop_sequence_set) begin
         sda_oe <= 1'b1;
      end else if (state == ST_SDA_WAIT && baud_tmo) begin
         sda_oe <= 1'b0;
      end
   end

   // open-drain pins only ever pull low. the data bits are kept as
   // flops so every output leaves a register; the pad combines them
   // with the enables above
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // enable bit: set by software, cleared by hardware at completion;
   // a request while busy finds the state not idle and is dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stop_sequence_enable <= 1'b0;
      end else if (state == ST_IDLE && stop_sequence_set) begin
         stop_sequence_enable <= 1'b1;
      end else if (stop_done) begin
         stop_sequence_enable <= 1'b0;
      end
   end

   // stop seen: sda high while scl high in the final period. sticky
   // until cleared; a set in the same cycle as a clear wins so an
   // event cannot be lost to a racing software clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stop_detected <= 1'b0;
      end else if (state == ST_DONE && sda_in && scl_in) begin
         stop_detected <= 1'b1;
      end else if (stop_clr) begin
         stop_detected <= 1'b0;
      end
   end

   // completion flag; the set beats a same-cycle clear
   // so software polling and clearing cannot swallow a completion
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         serial_port_irq_flag <= 1'b0;
      end else if (stop_done) begin
         serial_port_irq_flag <= 1'b1;
      end else if (irq_clr) begin
         serial_port_irq_flag <= 1'b0;
      end
   end

   // buffer writes are refused for the whole stop sequence; the
   // collision set wins over a same-cycle clear, and a refused write
   // leaves the old contents in place
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         transfer_buffer      <= BUF_RESET;
         write_collision_flag <= 1'b0;
      end else if (buf_wr && stop_sequence_enable) begin
         write_collision_flag <= 1'b1;
      end else begin
         // a write outside the sequence simply lands
         if (buf_wr) begin
            transfer_buffer <= buf_wdata;
         end
         if (write_collision_flag_clr) begin
            write_collision_flag <= 1'b0;
         end
      end
   end
endmodule : i2sq_stop
`default_nettype wire

// File: i2sq_stop_asserts.sv
/* port checker for the stop sequencer.
 assumes one clock, bus lines resolved outside the block. */
`timescale 1ns/1ps
`default_nettype none
module i2sq_stop_asserts
   import i2sq_pkg::*;
(
   input wire logic              sys_clk,              // system clock
   input wire logic              rst,                  // async reset, high
   input wire logic              xfer_end,             // ninth fall seen
   input wire logic              stop_sequence_set,    // stop request
   input wire logic              buf_wr,               // buffer write
   input wire logic              scl_in,               // scl line level
   input wire logic              sda_in,               // sda line level
   input wire logic              scl_oe,               // scl pulled low
   input wire logic              sda_oe,               // sda pulled low
   input wire logic              stop_sequence_enable, // stop in progress
   input wire logic              stop_detected,        // stop seen
   input wire logic              serial_port_irq_flag, // completion flag
   input wire logic              write_collision_flag, // write refused
   input wire logic [BAUD_W-1:0] baud_reload_period,   // period value
   input wire logic [DATA_W-1:0] buf_wdata,            // write data
   input wire logic [DATA_W-1:0] transfer_buffer       // buffer contents
);
   logic [2:0] last; // line state one edge ago
   logic [7:0] cnt;  // edges since a line last moved
   logic [7:0] p;    // widened period
   assign p = {1'b0, baud_reload_period};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // restart on any line move so stretching restarts the wait
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         last <= 3'h0;
         cnt <= 8'h00;
      end else begin
         last <= {scl_oe, sda_oe, scl_in};
         if (last != {scl_oe, sda_oe, scl_in})
            cnt <= 8'h00;
         else if (cnt != 8'hff)
            cnt <= cnt + 8'h01;
      end
   end
   a_scl_held: assert property (xfer_end |=> scl_oe)
      else $error("scl not held low");
   a_sda_first: assert property (stop_sequence_set && !stop_sequence_enable
      |=> stop_sequence_enable && sda_oe) else $error("sda not pulled first");
   a_scl_early: assert property ($fell(scl_oe) |-> cnt >= p)
      else $error("scl released early");
   a_scl_late: assert property (stop_sequence_enable && scl_oe && !sda_in
      |-> cnt <= p + 8'h04) else $error("scl release late");
   a_sda_early: assert property ($fell(sda_oe) |-> scl_in && cnt >= p)
      else $error("sda released early");
   a_sda_late: assert property (stop_sequence_enable && sda_oe && scl_in
      |-> cnt <= p + 8'h04) else $error("sda release late");
   a_stop_seen: assert property ($rose(stop_detected)
      |-> $past(sda_in) && $past(scl_in)) else $error("stop flag cause");
   a_stop_done: assert property ($fell(stop_sequence_enable)
      |-> serial_port_irq_flag && stop_detected && cnt >= p)
      else $error("stop completion wrong");
   a_write_collision_flag_drop: assert property (buf_wr && stop_sequence_enable
      |=> write_collision_flag && $stable(transfer_buffer))
      else $error("write not refused");
endmodule // i2sq_stop_asserts
bind i2sq_stop i2sq_stop_asserts i2sq_stop_asserts_inst (
   .sys_clk              (sys_clk),
   .rst                  (rst),
   .xfer_end             (xfer_end),
   .stop_sequence_set    (stop_sequence_set),
   .buf_wr               (buf_wr),
   .scl_in               (scl_in),
   .sda_in               (sda_in),
   .scl_oe               (scl_oe),
   .sda_oe               (sda_oe),
   .stop_sequence_enable (stop_sequence_enable),
   .stop_detected        (stop_detected),
   .serial_port_irq_flag (serial_port_irq_flag),
   .write_collision_flag (write_collision_flag),
   .baud_reload_period   (baud_reload_period),
   .buf_wdata            (buf_wdata),
   .transfer_buffer      (transfer_buffer)
);
`default_nettype wire

// File: i2sq_bus_model.sv
/* bus model: pulled-up scl and sda, one slave that stretches scl.
 assumes oe high means the master pulls the line low. */
`timescale 1ns/1ps
`default_nettype none
module i2sq_bus_model (
   input  wire logic       sys_clk, // system clock
   input  wire logic       scl_oe,  // master pulls scl
   input  wire logic       sda_oe,  // master pulls sda
   input  wire logic [3:0] stretch, // slave hold-off cycles
   output logic            scl_in,  // resolved scl
   output logic            sda_in   // resolved sda
);
   logic [3:0] hold = 4'h0; // cycles the slave still pulls scl
   // slave keeps scl low a while after the master lets go
   always_ff @(posedge sys_clk) begin
      if (scl_oe)
         hold <= stretch;
      else if (hold != 4'h0)
         hold <= hold - 4'h1;
   end
   assign scl_in = !scl_oe && hold == 4'h0;
   assign sda_in = !sda_oe; // pull-up wins when released
endmodule // i2sq_bus_model
`default_nettype wire

// File: test_i2sq_stop.sv
/* bench: stop sequences with and without slave stretching.
 assumes the bus model and checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module test_i2sq_stop;
   import i2sq_pkg::*;
   logic sys_clk = 0, rst = 1, xfer_end = 0, stop_sequence_set = 0;
   logic buf_wr = 0, write_collision_flag_clr = 0, irq_clr = 0, stop_clr = 0;
   logic scl_in, sda_in, scl_oe, sda_oe, scl_out, sda_out;
   logic stop_sequence_enable, stop_detected;
   logic serial_port_irq_flag, write_collision_flag;
   logic [BAUD_W-1:0] baud_reload_period = 7'h03;
   logic [DATA_W-1:0] buf_wdata = 8'h00, transfer_buffer;
   logic [3:0] stretch = 4'h0;
   int mismatches = 0, checks = 0, n;
   localparam logic [5:0] PL_XFER = 6'h01; // ninth clock fall seen
   localparam logic [5:0] PL_SET  = 6'h02; // software stop request
   localparam logic [5:0] PL_WR   = 6'h04; // buffer write
   localparam logic [5:0] PL_CLR  = 6'h38; // all three flag clears
   localparam logic [1:0] W_SCL   = 2'h0;  // watch scl_oe
   localparam logic [1:0] W_SDA   = 2'h1;  // watch sda_oe
   localparam logic [1:0] W_EN    = 2'h2;  // watch the enable bit
   // clock: inverted every half period
   always #12.5 sys_clk = ~sys_clk;
   i2sq_stop i2sq_stop_inst (
      .sys_clk              (sys_clk),
      .rst                  (rst),
      .xfer_end             (xfer_end),
      .stop_sequence_set    (stop_sequence_set),
      .baud_reload_period   (baud_reload_period),
      .buf_wr               (buf_wr),
      .buf_wdata            (buf_wdata),
      .write_collision_flag_clr             (write_collision_flag_clr),
      .irq_clr              (irq_clr),
      .stop_clr             (stop_clr),
      .scl_in               (scl_in),
      .sda_in               (sda_in),
      .scl_oe               (scl_oe),
      .scl_out              (scl_out),
      .sda_oe               (sda_oe),
      .sda_out              (sda_out),
      .stop_sequence_enable (stop_sequence_enable),
      .stop_detected        (stop_detected),
      .serial_port_irq_flag (serial_port_irq_flag),
      .write_collision_flag (write_collision_flag),
      .transfer_buffer      (transfer_buffer)
   );
   i2sq_bus_model i2sq_bus_model_inst (
      .sys_clk (sys_clk),
      .scl_oe  (scl_oe),
      .sda_oe  (sda_oe),
      .stretch (stretch),
      .scl_in  (scl_in),
      .sda_in  (sda_in)
   );
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one-cycle strobes, raised and dropped on rising edges
   task automatic pulse(input logic [5:0] sel);
      @(posedge sys_clk);
      {stop_clr, irq_clr, write_collision_flag_clr, buf_wr, stop_sequence_set,
       xfer_end} <= sel;
      @(posedge sys_clk);
      {stop_clr, irq_clr, write_collision_flag_clr, buf_wr, stop_sequence_set,
       xfer_end} <= 6'h00;
      @(negedge sys_clk);
   endtask
   // level of the watched output
   function automatic logic level(input logic [1:0] sel);
      if (sel == W_SCL)
         return scl_oe;
      else if (sel == W_SDA)
         return sda_oe;
      else
         return stop_sequence_enable;
   endfunction
   // bounded wait while a level stays high, counted in falling edges
   task automatic span(input logic [1:0] sel);
      n = 0;
      while (level(sel) === 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   // one full stop sequence; data differs per run so a write shows
   task automatic stop_run(logic [6:0] p, logic [3:0] s);
      logic [7:0] d; // data for this run
      d = 8'ha5 ^ {1'b0, p};
      @(posedge sys_clk);
      baud_reload_period <= p;
      stretch <= s;
      buf_wdata <= d;
      pulse(PL_WR);
      chk("buffer", d, transfer_buffer);
      pulse(PL_XFER);
      chk("scl_hold", 8'h01, {7'h0, scl_oe});
      pulse(PL_SET);
      chk("sda_first", 8'h03, {6'h0, sda_oe, stop_sequence_enable});
      span(W_SCL);
      chk("scl_wait", 8'h01, {7'h0, n >= p && n <= p + 4});
      @(posedge sys_clk);
      buf_wdata <= ~d;
      pulse(PL_WR);
      chk("write_collision_flag", 8'h01, {7'h0, write_collision_flag});
      chk("kept", d, transfer_buffer);
      span(W_SDA);
      chk("sda_wait", 8'h01, {7'h0, n + 2 >= s + p && n <= s + p + 5});
      span(W_EN);
      chk("end_wait", 8'h01, {7'h0, n >= p && n <= p + 5});
      chk("stop", 8'h07, {5'h0, stop_detected, serial_port_irq_flag,
                          scl_in & sda_in});
      pulse(PL_CLR);
      chk("cleared", 8'h00, {3'h0, scl_out, sda_out, write_collision_flag,
                             serial_port_irq_flag, stop_detected});
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      @(negedge sys_clk);
      chk("reset", 8'h00, {4'h0, scl_oe, sda_oe, stop_sequence_enable,
                           serial_port_irq_flag});
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      stop_run(7'h03, 4'h0);
      stop_run(7'h05, 4'h4);
      stop_run(7'h00, 4'h0);
      complete_run;
   end
   // the three runs take a few hundred cycles at most
   initial begin
      #100000;
      mismatches++;
      complete_run;
   end
endmodule // test_i2sq_stop
`default_nettype wire
